// ### verilog/adc_regs_pkg.sv
package adc_regs_pkg;

  // Register addresses on the 13-bit serial address field.
  localparam logic [12:0] ADDR_PORT_CFG   = 13'h000;
  localparam logic [12:0] ADDR_PART_ID    = 13'h001;
  localparam logic [12:0] ADDR_GRADE      = 13'h002;
  localparam logic [12:0] ADDR_CHAN_SEL   = 13'h005;
  localparam logic [12:0] ADDR_POWER      = 13'h008;
  localparam logic [12:0] ADDR_SYNTH_EN   = 13'h009;
  localparam logic [12:0] ADDR_SYNTH_CTL  = 13'h00a;
  localparam logic [12:0] ADDR_IN_BW      = 13'h00f;
  localparam logic [12:0] ADDR_OUT_MODE   = 13'h014;
  localparam logic [12:0] ADDR_OUT_DRIVE  = 13'h015;
  localparam logic [12:0] ADDR_OUT_CLOCK  = 13'h016;
  localparam logic [12:0] ADDR_REF_SEL    = 13'h018;
  localparam logic [12:0] ADDR_RATE_CORR  = 13'h101;
  localparam logic [12:0] ADDR_OVERRANGE  = 13'h111;
  localparam logic [12:0] ADDR_CORR_CTL   = 13'h112;
  localparam logic [12:0] ADDR_CORR_FORCE = 13'h113;

  // Field positions.
  localparam int BIT_ORDER_HI   = 6;
  localparam int BIT_ORDER_LO   = 1;
  localparam int DEFAULT_CMD_HI = 5;
  localparam int DEFAULT_CMD_LO = 2;
  localparam int SYNTH_EN_BIT   = 2;
  localparam int LOCK_BIT       = 7;
  localparam int AUTOBAND_BIT   = 6;
  localparam int INTERLEAVE_BIT = 5;
  localparam int TRISTATE_BIT   = 4;
  localparam int INVERT_BIT     = 2;
  localparam int EXT_REF_BIT    = 6;
  localparam int QUAD_CORR_BIT  = 6;
  localparam int FILTER_IND_BIT = 7;

  // Reset values and fixed read values.
  localparam logic [7:0] PORT_CFG_FIXED  = 8'h18;
  localparam logic [7:0] OUT_DRIVE_RESET = 8'h02;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // Channel select codes.
  localparam logic [1:0] CHAN_BOTH0 = 2'h0;
  localparam logic [1:0] CHAN_A     = 2'h1;
  localparam logic [1:0] CHAN_B     = 2'h2;
  localparam logic [1:0] CHAN_BOTH3 = 2'h3;

  // Power state codes.
  localparam logic [1:0] PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PWR_LOCAL   = 2'h1;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [1:0] PWR_SLEEP   = 2'h3;

  // Grade codes.
  localparam logic [7:0] GRADE_10MHZ = 8'h00;
  localparam logic [7:0] GRADE_5MHZ  = 8'h10;
  localparam logic [7:0] GRADE_2M5HZ = 8'h20;

  // Frame lengths: 16 instruction bits, 8 data bits.
  localparam int HDR_BITS  = 16;
  localparam int DATA_BITS = 8;

  // Decoded control fields handed to the converter core.
  typedef struct packed {
    logic [1:0] powerStateSel;
    logic       synthEnable;
    logic       synthAutoband;
    logic [5:0] synthMultiplier;
    logic       externalRefSel;
    logic       quadCorrEnable;
    logic [5:0] outputRateSel;
    logic [2:0] coefFreeze;
    logic [2:0] corrDisable;
    logic [2:0] coefForce;
    logic       chanAWrite;
    logic       chanBWrite;
  } core_ctrl_type;

endpackage

// ### verilog/adc_control_register_bank.sv
// Operation
// [RULE1] Bit-order bit picks MSB or LSB first
// [RULE2] Default command resets all but three registers
// [RULE3] Grade field reports bandwidth option code
// [RULE4] Channel select steers channel register writes
// [RULE5] Power field selects normal, down, standby, sleep
// [RULE6] Lock bit reads live loop lock
// [RULE7] Autoband bit and six-bit multiplier field
// [RULE8] Interleave puts both channels on bus A
// [RULE9] Tristate bit floats data output pins
// [RULE10] Invert bit inverts every output bit
// [RULE11] Reference bit selects external reference
// [RULE12] Rate register bit enables quadrature correction
// [RULE13] Low six bits select output rate
// [RULE14] Indicator bit routes filter resets to pin
// [RULE15] Freeze bits hold dc, phase, gain coefficients
// [RULE16] Disable bits turn off each correction
// [RULE17] Force bits load initial static coefficients
// [RULE18] Host drives clock, select; data pin shared
// [RULE19] Lock bit live, writes ignored
// [RULE20] Identifier and grade registers are read-only
`timescale 1ns/1ps
`default_nettype none

module adc_control_register_bank #(
  parameter logic [7:0] PART_ID = 8'h5a,  // Arbitrary neutral identifier value.
  parameter logic [1:0] GRADE   = 2'h0
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // Serial port pins.
  input  wire logic                        serialClock,
  input  wire logic                        serial_select_n,
  input  wire logic                        serialDataIn,
  output logic                             serialDataOut,
  output logic                             serialDataOe,
  // Converter core status.
  input  wire logic                        synthLocked,
  input  wire logic                        filterResetA,
  input  wire logic                        filterResetB,
  input  wire logic                        overrangeA,
  input  wire logic                        overrangeB,
  input  wire logic [15:0]                 sampleA,
  input  wire logic [15:0]                 sampleB,
  // Converter controls and output pins.
  output adc_regs_pkg::core_ctrl_type      coreCtrl,
  output logic                             overrangePinA,
  output logic                             overrangePinB,
  output logic [15:0]                      dataOutA,
  output logic [15:0]                      dataOutB,
  output logic                             dataOutOe
);

  typedef enum logic [2:0] {
    IDLE = 3'b001,
    HDR  = 3'b010,
    DATA = 3'b100
  } phase_type;

  // Synchronised pin copies.
  logic [1:0] sclkSync;
  logic [1:0] csSync;
  logic [1:0] sdiSync;
  logic       sclkLast;
  logic       sclkRise;
  logic       sclkFall;
  logic       csActive;

  // Serial engine state.
  phase_type  phase;
  logic [4:0] bitCount;
  logic [15:0] shiftIn;
  logic [7:0] shiftOut;
  logic       readOp;
  logic [12:0] addr;
  logic       writeStrobe;
  logic [7:0] writeData;
  logic [15:0] next_hdr;
  logic [7:0] next_data;
  logic [7:0] readData;

  // Register storage.
  logic [7:0] portCfg;
  logic [1:0] chanSel;
  logic [1:0] powerSel;
  logic       synthEn;
  logic [6:0] synthCtl;
  logic [1:0] inputBw;
  logic [7:0] outMode;
  logic [7:0] outDrive;
  logic [7:0] outClock;
  logic [7:0] refSel;
  logic [7:0] rateCorr;
  logic [7:0] overrange;
  logic [5:0] corrCtl;
  logic [2:0] corrForce;
  logic       bit_order_sel;
  logic       defaultCmd;
  logic       interleaveSel;
  logic       interleavePhase;

  // Two flip-flops on every serial port pin before any logic reads it.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclkSync <= 2'h0;
      csSync   <= 2'h3;
      sdiSync  <= 2'h0;
      sclkLast <= 1'b0;
    end
    else
    begin
      sclkSync <= {sclkSync[0], serialClock};      // RULE18
      csSync   <= {csSync[0], serial_select_n};    // RULE18
      sdiSync  <= {sdiSync[0], serialDataIn};
      sclkLast <= sclkSync[1];
    end
  end

  // Edge and select decode from the second stages only.
  assign sclkRise   = sclkSync[1] & ~sclkLast;
  assign sclkFall   = ~sclkSync[1] & sclkLast;
  assign csActive   = ~csSync[1];
  assign bit_order_sel   = portCfg[adc_regs_pkg::BIT_ORDER_HI] | portCfg[adc_regs_pkg::BIT_ORDER_LO];
  assign defaultCmd = portCfg[adc_regs_pkg::DEFAULT_CMD_HI] | portCfg[adc_regs_pkg::DEFAULT_CMD_LO];

  // Incoming bit appended according to the chosen bit order.
  always_comb
  begin
    next_hdr  = bit_order_sel ? {sdiSync[1], shiftIn[15:1]} : {shiftIn[14:0], sdiSync[1]}; // RULE1
    next_data = bit_order_sel ? {sdiSync[1], shiftIn[7:1]} : {shiftIn[6:0], sdiSync[1]};   // RULE1
  end

  // Frame sequencer: header, then one data byte per address.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase       <= IDLE;
      bitCount    <= 5'h00;
      shiftIn     <= 16'h0000;
      readOp      <= 1'b0;
      addr        <= 13'h0000;
      writeStrobe <= 1'b0;
      writeData   <= 8'h00;
    end
    else
    begin
      writeStrobe <= 1'b0;
      if (!csActive)
      begin
        phase    <= IDLE;
        bitCount <= 5'h00;
      end
      else
      begin
        case (phase)
          IDLE:
          begin
            phase    <= HDR;
            bitCount <= 5'h00;
          end
          HDR:
          begin
            if (sclkRise)
            begin
              shiftIn <= next_hdr;
              if (bitCount == 5'(adc_regs_pkg::HDR_BITS - 1))
              begin
                // Header is R/W, two length bits, thirteen address bits; the shifter
                // already restores the bit order, so both modes decode alike.
                readOp   <= next_hdr[15];
                addr     <= next_hdr[12:0];
                bitCount <= 5'h00;
                phase    <= DATA;
              end
              else
              begin
                bitCount <= bitCount + 5'h01;
              end
            end
          end
          DATA:
          begin
            if (sclkRise)
            begin
              shiftIn <= {8'h00, next_data};
              if (bitCount == 5'(adc_regs_pkg::DATA_BITS - 1))
              begin
                bitCount    <= 5'h00;
                writeStrobe <= ~readOp;
                writeData   <= next_data;
                // Streaming walks down in MSB mode and up in LSB mode.
                addr        <= bit_order_sel ? addr + 13'h0001 : addr - 13'h0001;
              end
              else
              begin
                bitCount <= bitCount + 5'h01;
              end
            end
          end
          default:
          begin
            phase <= IDLE;
          end
        endcase
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    case (addr)
      adc_regs_pkg::ADDR_PORT_CFG:   readData = portCfg | adc_regs_pkg::PORT_CFG_FIXED;
      adc_regs_pkg::ADDR_PART_ID:    readData = PART_ID;                       // RULE20
      adc_regs_pkg::ADDR_GRADE:      readData = {2'h0, GRADE, 4'h0};           // RULE3
      adc_regs_pkg::ADDR_CHAN_SEL:   readData = {6'h00, chanSel};
      adc_regs_pkg::ADDR_POWER:      readData = {6'h00, powerSel};
      adc_regs_pkg::ADDR_SYNTH_EN:   readData = {5'h00, synthEn, 2'h0};
      adc_regs_pkg::ADDR_SYNTH_CTL:  readData = {synthLocked, synthCtl};       // RULE6 RULE19
      adc_regs_pkg::ADDR_IN_BW:      readData = {1'b0, inputBw, 5'h00};
      adc_regs_pkg::ADDR_OUT_MODE:   readData = outMode;
      adc_regs_pkg::ADDR_OUT_DRIVE:  readData = outDrive;
      adc_regs_pkg::ADDR_OUT_CLOCK:  readData = outClock;
      adc_regs_pkg::ADDR_REF_SEL:    readData = refSel;
      adc_regs_pkg::ADDR_RATE_CORR:  readData = rateCorr;
      adc_regs_pkg::ADDR_OVERRANGE:  readData = overrange;
      adc_regs_pkg::ADDR_CORR_CTL:   readData = {2'h0, corrCtl};
      adc_regs_pkg::ADDR_CORR_FORCE: readData = {5'h00, corrForce};
      default:                       readData = 8'h00;
    endcase
  end

  // Readback shifter: loads at the end of the header, shifts on falling edges.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shiftOut     <= 8'h00;
      serialDataOe <= 1'b0;
    end
    else if (!csActive || !readOp || phase != DATA)
    begin
      serialDataOe <= 1'b0;
      shiftOut     <= readData;
    end
    else
    begin
      serialDataOe <= 1'b1;                                                    // RULE18
      if (sclkFall && bitCount != 5'h00)
      begin
        shiftOut <= bit_order_sel ? {1'b0, shiftOut[7:1]} : {shiftOut[6:0], 1'b0}; // RULE1
      end
      else if (sclkFall)
      begin
        shiftOut <= readData;
      end
    end
  end

  assign serialDataOut = bit_order_sel ? shiftOut[0] : shiftOut[7];

  // Port configuration; mirrored bits are written as a pair, default bits self-clear.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      portCfg <= adc_regs_pkg::REG_RESET;
    end
    else if (writeStrobe && (bit_order_sel ? addr - 13'h0001 : addr + 13'h0001)
             == adc_regs_pkg::ADDR_PORT_CFG)
    begin
      portCfg <= writeData & 8'h66;
    end
    else if (defaultCmd)
    begin
      portCfg <= portCfg & 8'h42;                                              // RULE2
    end
  end

  // Synthesizer registers survive the default command.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      synthEn  <= 1'b0;
      synthCtl <= 7'h00;
    end
    else if (writeStrobe)
    begin
      if ((bit_order_sel ? addr - 13'h0001 : addr + 13'h0001) == adc_regs_pkg::ADDR_SYNTH_EN)
      begin
        synthEn <= writeData[adc_regs_pkg::SYNTH_EN_BIT];
      end
      if ((bit_order_sel ? addr - 13'h0001 : addr + 13'h0001) == adc_regs_pkg::ADDR_SYNTH_CTL)
      begin
        synthCtl <= writeData[6:0];                                            // RULE7 RULE19
      end
    end
  end

  // General registers; the default command returns them to reset values.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chanSel   <= 2'h0;
      powerSel  <= adc_regs_pkg::PWR_NORMAL;
      inputBw   <= 2'h0;
      outMode   <= adc_regs_pkg::REG_RESET;
      outDrive  <= adc_regs_pkg::OUT_DRIVE_RESET;
      outClock  <= adc_regs_pkg::REG_RESET;
      refSel    <= adc_regs_pkg::REG_RESET;
      rateCorr  <= adc_regs_pkg::REG_RESET;
      overrange <= adc_regs_pkg::REG_RESET;
      corrCtl   <= 6'h00;
      corrForce <= 3'h0;
    end
    else if (defaultCmd)
    begin
      chanSel   <= 2'h0;                                                       // RULE2
      powerSel  <= adc_regs_pkg::PWR_NORMAL;
      inputBw   <= 2'h0;
      outMode   <= adc_regs_pkg::REG_RESET;
      outDrive  <= adc_regs_pkg::OUT_DRIVE_RESET;
      outClock  <= adc_regs_pkg::REG_RESET;
      refSel    <= adc_regs_pkg::REG_RESET;
      rateCorr  <= adc_regs_pkg::REG_RESET;
      overrange <= adc_regs_pkg::REG_RESET;
      corrCtl   <= 6'h00;
      corrForce <= 3'h0;
    end
    else if (writeStrobe)
    begin
      case (bit_order_sel ? addr - 13'h0001 : addr + 13'h0001)
        adc_regs_pkg::ADDR_CHAN_SEL:   chanSel   <= writeData[1:0];            // RULE4
        adc_regs_pkg::ADDR_POWER:      powerSel  <= writeData[1:0];            // RULE5
        adc_regs_pkg::ADDR_IN_BW:      inputBw   <= writeData[6:5];
        adc_regs_pkg::ADDR_OUT_MODE:   outMode   <= writeData & 8'hb7;
        adc_regs_pkg::ADDR_OUT_DRIVE:  outDrive  <= writeData & 8'h0f;
        adc_regs_pkg::ADDR_OUT_CLOCK:  outClock  <= writeData & 8'h80;
        adc_regs_pkg::ADDR_REF_SEL:    refSel    <= writeData & 8'h40;         // RULE11
        adc_regs_pkg::ADDR_RATE_CORR:  rateCorr  <= writeData & 8'h7f;         // RULE12 RULE13
        adc_regs_pkg::ADDR_OVERRANGE:  overrange <= writeData;                 // RULE14
        adc_regs_pkg::ADDR_CORR_CTL:   corrCtl   <= writeData[5:0];            // RULE15 RULE16
        adc_regs_pkg::ADDR_CORR_FORCE: corrForce <= writeData[2:0];            // RULE17
        default:                       chanSel   <= chanSel;                   // RULE20
      endcase
    end
  end

  // Control fields to the converter core.
  always_comb
  begin
    coreCtrl.powerStateSel   = powerSel;                                       // RULE5
    coreCtrl.synthEnable     = synthEn;
    coreCtrl.synthAutoband   = synthCtl[adc_regs_pkg::AUTOBAND_BIT];           // RULE7
    coreCtrl.synthMultiplier = synthCtl[5:0];                                  // RULE7
    coreCtrl.externalRefSel  = refSel[adc_regs_pkg::EXT_REF_BIT];              // RULE11
    coreCtrl.quadCorrEnable  = rateCorr[adc_regs_pkg::QUAD_CORR_BIT];          // RULE12
    coreCtrl.outputRateSel   = rateCorr[5:0];                                  // RULE13
    coreCtrl.coefFreeze      = corrCtl[5:3];                                   // RULE15
    coreCtrl.corrDisable     = corrCtl[2:0];                                   // RULE16
    coreCtrl.coefForce       = corrForce;                                      // RULE17
    coreCtrl.chanAWrite      = chanSel != adc_regs_pkg::CHAN_B;                // RULE4
    coreCtrl.chanBWrite      = chanSel != adc_regs_pkg::CHAN_A;                // RULE4
  end

  assign interleaveSel = outMode[adc_regs_pkg::INTERLEAVE_BIT];

  // Output data path: interleave alternates channels on bus A, invert applies last.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interleavePhase <= 1'b0;
      dataOutA        <= 16'h0000;
      dataOutB        <= 16'h0000;
      dataOutOe       <= 1'b0;
      overrangePinA   <= 1'b0;
      overrangePinB   <= 1'b0;
    end
    else
    begin
      interleavePhase <= interleaveSel & ~interleavePhase;
      dataOutA <= (interleaveSel && interleavePhase ? sampleB : sampleA)     // RULE8
                  ^ {16{outMode[adc_regs_pkg::INVERT_BIT]}};                 // RULE10
      dataOutB <= sampleB ^ {16{outMode[adc_regs_pkg::INVERT_BIT]}};         // RULE10
      dataOutOe <= ~outMode[adc_regs_pkg::TRISTATE_BIT];                     // RULE9
      overrangePinA <= overrangeA
                       | (overrange[adc_regs_pkg::FILTER_IND_BIT] & filterResetA); // RULE14
      overrangePinB <= overrangeB
                       | (overrange[adc_regs_pkg::FILTER_IND_BIT] & filterResetB); // RULE14
    end
  end

  // Tristate bit takes the output enable off one cycle later.
  a_tristate_follows: assert property (@(posedge clk) disable iff (!rst_b)
    outMode[adc_regs_pkg::TRISTATE_BIT] |=> !dataOutOe)                     // RULE9
    else $error("Data outputs driven while tristate bit set.");

  // Invert bit gives the complement of channel B on bus B.
  a_invert_applies: assert property (@(posedge clk) disable iff (!rst_b)
    outMode[adc_regs_pkg::INVERT_BIT] |=> dataOutB == ~$past(sampleB))       // RULE10
    else $error("Output data not inverted.");

  // Lock bit in readback equals the live lock input.
  a_lock_live: assert property (@(posedge clk) disable iff (!rst_b)
    addr == adc_regs_pkg::ADDR_SYNTH_CTL |-> readData[adc_regs_pkg::LOCK_BIT] == synthLocked) // RULE6
    else $error("Lock bit does not follow the loop.");

  // Channel A select enables channel A writes and not channel B.
  a_channel_route: assert property (@(posedge clk) disable iff (!rst_b)
    (chanSel == adc_regs_pkg::CHAN_A) |-> (coreCtrl.chanAWrite && !coreCtrl.chanBWrite)) // RULE4
    else $error("Channel A select routed wrongly.");

  // Default command returns general registers to reset values but keeps the synthesizer.
  a_default_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    defaultCmd && !writeStrobe |=> outMode == 8'h00 && synthCtl == $past(synthCtl)) // RULE2
    else $error("Default command effect wrong.");

  // Filter reset indication reaches the pin when enabled.
  a_filter_pin: assert property (@(posedge clk) disable iff (!rst_b)
    overrange[adc_regs_pkg::FILTER_IND_BIT] && filterResetA |=> overrangePinA) // RULE14
    else $error("Filter reset not shown on pin.");

  // Data pin is driven only while reading.
  a_sdo_read_only: assert property (@(posedge clk) disable iff (!rst_b)
    serialDataOe |-> $past(readOp) || readOp)                                 // RULE18
    else $error("Data pin driven outside readback.");

  // Interleave alternates the two channels on bus A.
  a_interleave_alt: assert property (@(posedge clk) disable iff (!rst_b)
    interleaveSel && interleavePhase && !outMode[adc_regs_pkg::INVERT_BIT]
    |=> dataOutA == $past(sampleB))                                           // RULE8
    else $error("Interleave did not place channel B on bus A.");

endmodule

`default_nettype wire

// ### verification/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Serial host that frames register accesses towards the bank.
module serial_host_model (
  // Pacing clock.
  input  wire logic clk,
  // Serial pins towards the device.
  output logic      serialClock,
  output logic      serial_select_n,
  output logic      serialDataIn,
  input  wire logic serialDataOut,
  input  wire logic serialDataOe
);
  logic hostOe;
  logic hostBit;
  logic floatBit = 1'b0;
  logic bit_order_sel;

  // Between frames the clock stands low and the select is high.
  initial
  begin
    {serialClock, hostOe, hostBit, bit_order_sel} = '0;
    serial_select_n = 1'b1;
  end

  // A released data pin has no pull, so its level keeps moving.
  always @(negedge clk)
    floatBit <= ~floatBit;

  // The device drives the pin during readback, the host while hostOe is set.
  assign serialDataIn = serialDataOe ? serialDataOut : (hostOe ? hostBit : floatBit);

  // One frame: 16 header bits, then one byte; each clock phase lasts 6 cycles.
  task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] d,
                       output logic [7:0] q);
    logic [23:0] word;
    int          k;
    int          idx;
    word = {rd, 2'h0, a, d};
    q = 8'h00;
    @(negedge clk);
    serial_select_n = 1'b0;
    for (k = 0; k < 24; k++)
    begin
      idx = bit_order_sel ? (k < 16 ? k + 8 : k - 16) : 23 - k;
      hostOe = !(rd && k >= 16);
      hostBit = word[idx];
      repeat (6) @(negedge clk);
      if (k >= 16)
        q[idx] = serialDataIn;
      serialClock = 1'b1;
      repeat (6) @(negedge clk);
      serialClock = 1'b0;
    end
    repeat (6) @(negedge clk);
    serial_select_n = 1'b1;
    hostOe = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ### verification/adc_control_register_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench; all register traffic goes through the serial host.
module adc_control_register_bank_bench;
  typedef struct {logic [12:0] a; logic [7:0] w; logic [7:0] e;} row_type;
  logic        clk, rst_b, synthLocked, filterResetA, filterResetB, overrangeA, overrangeB;
  logic        sclk, selN, sdi, sdo, sdoOe, orA, orB, outOe;
  logic [15:0] sampleA, sampleB, dataOutA, dataOutB, w0;
  logic [7:0]  r;
  int          fail_count, compares, i;
  row_type     rows [12];
  adc_regs_pkg::core_ctrl_type ctrl;

  // Part identifier is an arbitrary value.
  adc_control_register_bank #(.PART_ID(8'h5a), .GRADE(2'h2)) dut (
    .clk(clk), .rst_b(rst_b), .serialClock(sclk), .serial_select_n(selN),
    .serialDataIn(sdi), .serialDataOut(sdo), .serialDataOe(sdoOe),
    .synthLocked(synthLocked), .filterResetA(filterResetA), .filterResetB(filterResetB),
    .overrangeA(overrangeA), .overrangeB(overrangeB), .sampleA(sampleA), .sampleB(sampleB),
    .coreCtrl(ctrl), .overrangePinA(orA), .overrangePinB(orB), .dataOutA(dataOutA),
    .dataOutB(dataOutB), .dataOutOe(outOe));

  serial_host_model host (
    .clk(clk), .serialClock(sclk), .serial_select_n(selN), .serialDataIn(sdi),
    .serialDataOut(sdo), .serialDataOe(sdoOe));

  // Free-running 200 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Reporting and comparison helpers.
  task automatic fail(input string m);
    fail_count++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task automatic checkReg(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
      fail($sformatf("register read %h expected %h", g, e));
  endtask
  task automatic checkWord(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e)
      fail($sformatf("output %h expected %h", g, e));
  endtask
  task automatic checkCtrl(input adc_regs_pkg::core_ctrl_type g,
                           input adc_regs_pkg::core_ctrl_type e);
    compares++;
    if (g !== e)
      fail($sformatf("controls %h expected %h", g, e));
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Register write, and register read with comparison.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.frame(1'b0, a, d, r);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    host.frame(1'b1, a, 8'h00, r);
    checkReg(r, e);
  endtask

  // Watchdog: all frames finish far inside this span.
  initial
  begin
    #300us;
    fail("watchdog expired");
    give_verdict;
  end

  // Main sequence.
  initial
  begin
    {rst_b, synthLocked, filterResetA, filterResetB, overrangeA, overrangeB} = '0;
    sampleA = 16'h1234;
    sampleB = 16'habcd;
    fail_count = 0;
    compares = 0;
    rows = '{'{13'h001, 8'h00, 8'h5a}, '{13'h002, 8'hff, 8'h20}, '{13'h005, 8'h02, 8'h02},
             '{13'h008, 8'h03, 8'h03}, '{13'h009, 8'h04, 8'h04}, '{13'h00a, 8'hff, 8'h7f},
             '{13'h018, 8'h40, 8'h40}, '{13'h101, 8'h7f, 8'h7f}, '{13'h111, 8'h80, 8'h80},
             '{13'h112, 8'h3f, 8'h3f}, '{13'h113, 8'h07, 8'h07}, '{13'h003, 8'hff, 8'h00}};
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    checkCtrl(ctrl, 29'h3);
    rdc(13'h000, 8'h18);
    rdc(13'h015, 8'h02);
    for (i = 0; i < 12; i++)
    begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e);
    end
    checkCtrl(ctrl, 29'h1ffffffd);
    for (i = 0; i < 4; i++)
    begin
      wr(13'h005, 8'(i));
      wr(13'h008, 8'(i));
      checkWord(16'({ctrl.powerStateSel, ctrl.chanAWrite, ctrl.chanBWrite}),
                16'({i[1:0], i != 2, i != 1}));
    end
    synthLocked = 1'b1;
    rdc(13'h00a, 8'hff);
    wr(13'h014, 8'h00);
    checkWord(dataOutA, 16'h1234);
    checkWord(dataOutB, 16'habcd);
    checkWord(16'(outOe), 16'h1);
    wr(13'h014, 8'h04);
    checkWord(dataOutA, 16'hedcb);
    checkWord(dataOutB, 16'h5432);
    wr(13'h014, 8'h10);
    checkWord(16'(outOe), 16'h0);
    wr(13'h014, 8'h20);
    w0 = dataOutA;
    @(negedge clk);
    checkWord(w0 ^ dataOutA, 16'h1234 ^ 16'habcd);
    filterResetA = 1'b1;
    filterResetB = 1'b1;
    wr(13'h111, 8'h80);
    checkWord(16'({orA, orB}), 16'h3);
    wr(13'h111, 8'h00);
    checkWord(16'({orA, orB}), 16'h0);
    wr(13'h000, 8'h24);
    rdc(13'h008, 8'h00);
    rdc(13'h112, 8'h00);
    rdc(13'h009, 8'h04);
    rdc(13'h00a, 8'hff);
    wr(13'h000, 8'h42);
    host.bit_order_sel = 1'b1;
    rdc(13'h000, 8'h5a);
    wr(13'h018, 8'h40);
    checkWord(16'(ctrl.externalRefSel), 16'h1);
    wr(13'h000, 8'h00);
    host.bit_order_sel = 1'b0;
    rdc(13'h000, 8'h18);
    give_verdict;
  end
endmodule
`default_nettype wire
